// File: rtl/ptp_label_map.svh
`ifndef PTP_LABEL_MAP_SVH
`define PTP_LABEL_MAP_SVH

// Field widths of the label bundle and of a request.
`define PTP_PART_W 16
`define PTP_MG_W 8
`define PTP_ADDR_W 32
`define PTP_DATA_W 32

// Exception levels, each with its own label register.
`define PTP_LEVELS 4
`define PTP_LEVEL_W 2

// Virtual-to-physical partition map depth and index width.
`define PTP_VMAP_N 8
`define PTP_VMAP_W 3

// Default label values of every partition space.
`define PTP_DEFAULT_PART 16'h0000
`define PTP_DEFAULT_MG 8'h00

// Implementation maxima; plain defaults that a system may override.
`define PTP_PROC_ID_MAX 16'h00FF
`define PTP_PROC_MG_MAX 8'hFF
`define PTP_COMP_NS_ID_MAX 16'h00FF
`define PTP_COMP_S_ID_MAX 16'h000F

`endif

// File: rtl/ptp_pkg.sv
package ptp_pkg;
  `include "ptp_label_map.svh"

  typedef struct packed {
    logic [`PTP_PART_W-1:0] partition_id;
    logic [`PTP_MG_W-1:0] monitor_group;
    logic label_space_nonsecure;
  } ptp_label_t;

  typedef struct packed {
    logic [`PTP_PART_W-1:0] partition_id;
    logic [`PTP_MG_W-1:0] monitor_group;
  } ptp_level_reg_t;

  typedef struct packed {
    logic [`PTP_ADDR_W-1:0] addr;
    logic write;
    logic [`PTP_DATA_W-1:0] data;
  } ptp_req_t;

  typedef enum logic {
    PTP_TS_IDLE,
    PTP_TS_ISSUE
  } ptp_term_state_t;
endpackage

// File: rtl/ptp_vmap.sv
`timescale 1ns/1ns
module ptp_vmap
  import ptp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [`PTP_VMAP_W-1:0] wr_idx,
  input wire logic [`PTP_PART_W-1:0] wr_phys,
  input wire logic [`PTP_PART_W-1:0] virt_id,
  output logic [`PTP_PART_W-1:0] phys_id,
  output logic miss
);
  logic [`PTP_PART_W-1:0] map_q [`PTP_VMAP_N];

  // Each map entry is a physical partition id, cleared to the default.
  for (genvar i = 0; i < `PTP_VMAP_N; i++) begin : g_entry
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        map_q[i] <= `PTP_DEFAULT_PART;
      end else if (wr_en && wr_idx == `PTP_VMAP_W'(i)) begin
        map_q[i] <= wr_phys;
      end
    end
  end

  // A virtual id beyond the table cannot be mapped and counts as an error.
  assign miss = virt_id >= `PTP_PART_W'(`PTP_VMAP_N);
  assign phys_id = miss ? `PTP_DEFAULT_PART
                        : map_q[virt_id[`PTP_VMAP_W-1:0]];
endmodule

// File: rtl/ptp_label_gen.sv
`timescale 1ns/1ns
module ptp_label_gen
  import ptp_pkg::*;
(
  input wire logic tagging_enable,
  input wire logic cur_secure,
  input wire logic virt_active,
  input wire ptp_level_reg_t sel_reg,
  input wire logic [`PTP_PART_W-1:0] mapped_id,
  input wire logic map_miss,
  input wire logic [`PTP_PART_W-1:0] id_max,
  input wire logic [`PTP_MG_W-1:0] mg_max,
  output ptp_label_t label,
  output logic part_err,
  output logic mg_err
);
  logic [`PTP_PART_W-1:0] phys_id;

  assign phys_id = virt_active ? mapped_id : sel_reg.partition_id;
  assign part_err = tagging_enable &&
                    ((virt_active && map_miss) || phys_id > id_max);
  assign mg_err = tagging_enable && sel_reg.monitor_group > mg_max;

  always_comb begin
    // The space bit follows the security state; no register holds it.
    label.label_space_nonsecure = !cur_secure;
    if (!tagging_enable || part_err) begin
      label.partition_id = `PTP_DEFAULT_PART;
    end else begin
      label.partition_id = phys_id;
    end
    // On either error the default group is chosen, the simpler option.
    if (!tagging_enable || part_err || mg_err) begin
      label.monitor_group = `PTP_DEFAULT_MG;
    end else begin
      label.monitor_group = sel_reg.monitor_group;
    end
  end
endmodule

// File: rtl/ptp_label_top.sv
`timescale 1ns/1ns
// Operation
// - Partition id field at most 16 bits
// - Monitor group field at most 8 bits
// - Label: partition id, group, space bit
// - Secure, nonsecure physical plus optional virtual spaces
// - Valid ids run zero to implementation maximum
// - Component shows secure and nonsecure id maxima
// - Default id is zero in each space
// - Tagging off gives default physical id
// - Generation error may give default id
// - Tagging off gives default monitor group
// - Group error: register value or default
// - Tagging on, no error: register group
// - Interfaces carry secure or nonsecure ids
// - Space bit comes from security state
// - Implement requester and terminating behaviours
// - Requester labels every downstream request fully
// - Terminating slave never forwards received labels
// - Memory commands carry no label
// - Labels never alter functional memory behaviour
// - Speculative requests use current label configuration
// - Id taken from current level's register
module ptp_label_top
  import ptp_pkg::*;
#(
  parameter logic [`PTP_PART_W-1:0] PROC_ID_MAX = `PTP_PROC_ID_MAX,
  parameter logic [`PTP_MG_W-1:0] PROC_MG_MAX = `PTP_PROC_MG_MAX,
  parameter logic [`PTP_PART_W-1:0] COMP_NS_ID_MAX = `PTP_COMP_NS_ID_MAX,
  parameter logic [`PTP_PART_W-1:0] COMP_S_ID_MAX = `PTP_COMP_S_ID_MAX
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tagging_enable,
  input wire logic [`PTP_LEVEL_W-1:0] cur_level,
  input wire logic cur_secure,
  input wire ptp_level_reg_t [`PTP_LEVELS-1:0] level_label_register,
  input wire logic [`PTP_LEVELS-1:0] virt_enable,
  input wire logic vmap_wr_en,
  input wire logic [`PTP_VMAP_W-1:0] vmap_wr_idx,
  input wire logic [`PTP_PART_W-1:0] vmap_wr_phys,
  output logic [`PTP_PART_W-1:0] processor_id_max,
  input wire logic req_in_valid,
  input wire ptp_req_t req_in,
  output logic req_in_ready,
  output logic dn_valid,
  output ptp_req_t dn_req,
  output ptp_label_t dn_label,
  output logic dn_gen_error,
  input wire logic dn_ready,
  output logic [`PTP_PART_W-1:0] component_nonsecure_id_max,
  output logic [`PTP_PART_W-1:0] component_secure_id_max,
  input wire logic up_valid,
  input wire ptp_req_t up_req,
  input wire ptp_label_t up_label,
  output logic up_ready,
  output logic up_range_error,
  output logic mem_cmd_valid,
  output ptp_req_t mem_cmd,
  input wire logic mem_cmd_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Requester label generation.

  ptp_level_reg_t sel_reg;
  logic virt_active;
  logic [`PTP_PART_W-1:0] mapped_id;
  logic map_miss;
  ptp_label_t gen_label;
  logic gen_part_err;
  logic gen_mg_err;
  logic req_take;

  assign sel_reg = level_label_register[cur_level];
  assign virt_active = virt_enable[cur_level];
  assign processor_id_max = PROC_ID_MAX;

  ptp_vmap u_vmap (
    .clk(clk),
    .reset(reset),
    .wr_en(vmap_wr_en),
    .wr_idx(vmap_wr_idx),
    .wr_phys(vmap_wr_phys),
    .virt_id(sel_reg.partition_id),
    .phys_id(mapped_id),
    .miss(map_miss)
  );

  ptp_label_gen u_gen (
    .tagging_enable(tagging_enable),
    .cur_secure(cur_secure),
    .virt_active(virt_active),
    .sel_reg(sel_reg),
    .mapped_id(mapped_id),
    .map_miss(map_miss),
    .id_max(PROC_ID_MAX),
    .mg_max(PROC_MG_MAX),
    .label(gen_label),
    .part_err(gen_part_err),
    .mg_err(gen_mg_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Requester output stage.

  assign req_in_ready = !dn_valid || dn_ready;
  assign req_take = req_in_valid && req_in_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dn_valid <= 1'b0;
    end else if (req_in_ready) begin
      dn_valid <= req_in_valid;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dn_req <= '0;
      dn_label <= '0;
      dn_gen_error <= 1'b0;
    end else if (req_take) begin
      dn_req <= req_in;
      dn_label <= gen_label;
      dn_gen_error <= gen_part_err || gen_mg_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminating slave toward the memory devices.

  ptp_term_state_t term_q;
  logic up_take;

  assign component_nonsecure_id_max = COMP_NS_ID_MAX;
  assign component_secure_id_max = COMP_S_ID_MAX;

  assign up_ready = term_q == PTP_TS_IDLE;
  assign up_take = up_valid && up_ready;
  assign mem_cmd_valid = term_q == PTP_TS_ISSUE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term_q <= PTP_TS_IDLE;
    end else begin
      case (term_q)
        PTP_TS_IDLE: begin
          if (up_valid) begin
            term_q <= PTP_TS_ISSUE;
          end
        end
        PTP_TS_ISSUE: begin
          if (mem_cmd_ready) begin
            term_q <= PTP_TS_IDLE;
          end
        end
        default: begin
          term_q <= PTP_TS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_cmd <= '0;
    end else if (up_take) begin
      mem_cmd <= up_req;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      up_range_error <= 1'b0;
    end else if (up_take) begin
      up_range_error <= up_label.label_space_nonsecure
                        ? up_label.partition_id > COMP_NS_ID_MAX
                        : up_label.partition_id > COMP_S_ID_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_hold_stable;
    dn_valid && !dn_ready |=> dn_valid && $stable(dn_label) && $stable(dn_req);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("label changed while request stalled");

  property p_off_part;
    req_take && !tagging_enable |=>
      dn_label.partition_id == `PTP_DEFAULT_PART && !dn_gen_error;
  endproperty
  a_off_part: assert property (p_off_part)
    else $error("tagging off did not give default id");

  property p_off_mg;
    req_take && !tagging_enable |=>
      dn_label.monitor_group == `PTP_DEFAULT_MG;
  endproperty
  a_off_mg: assert property (p_off_mg)
    else $error("tagging off did not give default group");

  property p_on_mg;
    req_take && tagging_enable && !gen_part_err && !gen_mg_err |=>
      dn_label.monitor_group == $past(sel_reg.monitor_group);
  endproperty
  a_on_mg: assert property (p_on_mg)
    else $error("group differs from level register");

  property p_phys_id;
    req_take && tagging_enable && !virt_active && !gen_part_err |=>
      dn_label.partition_id == $past(sel_reg.partition_id);
  endproperty
  a_phys_id: assert property (p_phys_id)
    else $error("id differs from level register");

  property p_err_default;
    req_take && gen_part_err |=> dn_gen_error &&
      dn_label.partition_id == `PTP_DEFAULT_PART;
  endproperty
  a_err_default: assert property (p_err_default)
    else $error("error did not force default id");

  property p_ns_state;
    req_take |=> dn_label.label_space_nonsecure == !$past(cur_secure);
  endproperty
  a_ns_state: assert property (p_ns_state)
    else $error("space bit not from security state");

  property p_in_range;
    dn_valid |-> dn_label.partition_id <= PROC_ID_MAX;
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("emitted id above maximum");

  property p_term_issue;
    up_take |=> mem_cmd_valid && mem_cmd == $past(up_req);
  endproperty
  a_term_issue: assert property (p_term_issue)
    else $error("terminated request not issued unchanged");

  property p_term_hold;
    mem_cmd_valid && !mem_cmd_ready |=> mem_cmd_valid && $stable(mem_cmd);
  endproperty
  a_term_hold: assert property (p_term_hold)
    else $error("memory command dropped while stalled");

  property p_no_accept_busy;
    mem_cmd_valid |-> !up_ready;
  endproperty
  a_no_accept_busy: assert property (p_no_accept_busy)
    else $error("upstream accepted while command pending");

  property p_req_answer;
    req_take |=> dn_valid;
  endproperty
  a_req_answer: assert property (p_req_answer)
    else $error("accepted request not presented downstream");

  property p_dn_release;
    dn_valid && dn_ready && !req_take |=> !dn_valid;
  endproperty
  a_dn_release: assert property (p_dn_release)
    else $error("downstream request repeated after acceptance");

  property p_virt_map;
    req_take && tagging_enable && virt_active && !gen_part_err |=>
      dn_label.partition_id == $past(mapped_id);
  endproperty
  a_virt_map: assert property (p_virt_map)
    else $error("virtual id not mapped to physical id");

  property p_virt_miss;
    req_take && tagging_enable && virt_active && map_miss |=>
      dn_gen_error && dn_label.partition_id == `PTP_DEFAULT_PART;
  endproperty
  a_virt_miss: assert property (p_virt_miss)
    else $error("unmapped virtual id did not give default id");

  property p_mg_err;
    req_take && tagging_enable && sel_reg.monitor_group > PROC_MG_MAX |=>
      dn_gen_error && dn_label.monitor_group == `PTP_DEFAULT_MG;
  endproperty
  a_mg_err: assert property (p_mg_err)
    else $error("group error did not give default group");

  property p_clean_flag;
    req_take && !gen_part_err && !gen_mg_err |=> !dn_gen_error;
  endproperty
  a_clean_flag: assert property (p_clean_flag)
    else $error("error flagged on a clean request");

  property p_range_ns;
    up_take && up_label.label_space_nonsecure |=>
      up_range_error == ($past(up_label.partition_id) > COMP_NS_ID_MAX);
  endproperty
  a_range_ns: assert property (p_range_ns)
    else $error("nonsecure range flag wrong");

  property p_range_s;
    up_take && !up_label.label_space_nonsecure |=>
      up_range_error == ($past(up_label.partition_id) > COMP_S_ID_MAX);
  endproperty
  a_range_s: assert property (p_range_s)
    else $error("secure range flag wrong");

  property p_mem_release;
    mem_cmd_valid && mem_cmd_ready |=> !mem_cmd_valid;
  endproperty
  a_mem_release: assert property (p_mem_release)
    else $error("memory command repeated after acceptance");

  property p_cov_off;
    req_take && !tagging_enable ##1 dn_valid && dn_ready;
  endproperty
  c_cov_off: cover property (p_cov_off);

  property p_cov_err;
    req_take && gen_part_err ##1 dn_valid;
  endproperty
  c_cov_err: cover property (p_cov_err);

  property p_cov_stall;
    dn_valid && !dn_ready ##1 dn_valid && dn_ready;
  endproperty
  c_cov_stall: cover property (p_cov_stall);

  property p_cov_term;
    up_take ##1 mem_cmd_valid && !mem_cmd_ready ##1 mem_cmd_ready;
  endproperty
  c_cov_term: cover property (p_cov_term);

  property p_cov_virt;
    req_take && tagging_enable && virt_active && !map_miss ##1 dn_valid;
  endproperty
  c_cov_virt: cover property (p_cov_virt);

endmodule

// File: dv/ptp_dn_partner.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Downstream component and memory device readiness. In slow mode both
// stall at random, so held requests and refusals get exercised.
module ptp_dn_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  output logic dn_ready,
  output logic mem_cmd_ready
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dn_ready <= 1'b0;
      mem_cmd_ready <= 1'b0;
    end else begin
      dn_ready <= !slow || ($urandom_range(0, 2) == 0);
      mem_cmd_ready <= !slow || ($urandom_range(0, 2) == 0);
    end
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  import ptp_pkg::*;
  localparam logic [15:0] ID_MAX = 16'h00FF;
  localparam logic [7:0] MG_MAX = 8'h0F;
  localparam logic [15:0] NS_MAX = 16'h00FF;
  localparam logic [15:0] S_MAX = 16'h000F;
  logic clk, reset, tagging_enable, cur_secure, vmap_wr_en, slow, run;
  logic [1:0] cur_level;
  ptp_level_reg_t [3:0] lvl_regs;
  logic [3:0] virt_enable;
  logic [2:0] vmap_wr_idx;
  logic [15:0] vmap_wr_phys, proc_max, ns_max, s_max;
  logic req_in_valid, req_in_ready, dn_valid, dn_gen_error, dn_ready;
  logic up_valid, up_ready, up_range_error, mem_cmd_valid, mem_cmd_ready;
  ptp_req_t req_in, dn_req, up_req, mem_cmd;
  ptp_label_t dn_label, up_label;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] vmap_m [8];
  logic [90:0] exp_dn [$];
  ptp_req_t exp_mem [$];
  logic [90:0] held;
  logic held_v = 1'b0, rng_due = 1'b0, rng_exp;

  ptp_label_top #(.PROC_MG_MAX(MG_MAX)) dut_u (.clk(clk), .reset(reset),
    .tagging_enable(tagging_enable), .cur_level(cur_level),
    .cur_secure(cur_secure), .level_label_register(lvl_regs),
    .virt_enable(virt_enable), .vmap_wr_en(vmap_wr_en),
    .vmap_wr_idx(vmap_wr_idx), .vmap_wr_phys(vmap_wr_phys),
    .processor_id_max(proc_max), .req_in_valid(req_in_valid),
    .req_in(req_in), .req_in_ready(req_in_ready), .dn_valid(dn_valid),
    .dn_req(dn_req), .dn_label(dn_label), .dn_gen_error(dn_gen_error),
    .dn_ready(dn_ready), .component_nonsecure_id_max(ns_max),
    .component_secure_id_max(s_max), .up_valid(up_valid),
    .up_req(up_req), .up_label(up_label), .up_ready(up_ready),
    .up_range_error(up_range_error), .mem_cmd_valid(mem_cmd_valid),
    .mem_cmd(mem_cmd), .mem_cmd_ready(mem_cmd_ready));

  ptp_dn_partner partner_u (.clk(clk), .reset(reset), .slow(slow),
    .dn_ready(dn_ready), .mem_cmd_ready(mem_cmd_ready));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Returns the expected {error, label} of a request taken now.
  function automatic logic [25:0] exp_label(input logic te, sec, v,
                                            input ptp_level_reg_t r);
    logic [15:0] id;
    logic [7:0] mg;
    logic err;
    id = r.partition_id;
    mg = r.monitor_group;
    err = 1'b0;
    if (!te) begin
      id = 16'h0000;
      mg = 8'h00;
    end else begin
      if (v && id > 16'h0007) err = 1'b1;
      else if (v) id = vmap_m[id[2:0]];
      if (id > ID_MAX) err = 1'b1;
      if (err) begin
        id = 16'h0000;
        mg = 8'h00;
      end else if (mg > MG_MAX) begin
        mg = 8'h00;
        err = 1'b1;
      end
    end
    return {err, id, mg, !sec};
  endfunction

  function automatic logic [15:0] rand_id();
    if ($urandom_range(0, 3) == 0) return 16'($urandom_range(0, 511));
    return 16'($urandom_range(0, 9));
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Random stimulus; a request and its qualifiers hold until taken.
  always @(posedge clk) begin
    if (!req_in_valid || req_in_ready) begin
      req_in_valid <= run && 1'($urandom);
      req_in <= {$urandom, 1'($urandom), $urandom};
      tagging_enable <= ($urandom_range(0, 3) != 0);
      cur_level <= 2'($urandom);
      cur_secure <= 1'($urandom);
      virt_enable <= 4'($urandom);
      for (int i = 0; i < 4; i++) begin
        lvl_regs[i] <= {rand_id(), 8'($urandom_range(0, 31))};
      end
    end
    if (!up_valid || up_ready) begin
      up_valid <= run && 1'($urandom);
      up_req <= {$urandom, 1'($urandom), $urandom};
      // some masters are tied off to the default label.
      up_label <= ($urandom_range(0, 3) == 0) ? {24'h000000, 1'($urandom)}
        : {rand_id(), 8'($urandom), 1'($urandom)};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference model and result comparison.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      end_of_test();
    end else if (!reset) begin
      if (req_in_valid && req_in_ready) begin
        exp_dn.push_back({req_in, exp_label(tagging_enable, cur_secure,
          virt_enable[cur_level], lvl_regs[cur_level])});
      end
      if (held_v) chk({dn_req, dn_gen_error, dn_label}, held);
      if (dn_valid && !dn_ready) chk(req_in_ready, 1'b0);
      if (dn_valid && dn_ready) begin
        chk({dn_req, dn_gen_error, dn_label}, exp_dn.pop_front());
      end
      held_v = dn_valid && !dn_ready;
      held = {dn_req, dn_gen_error, dn_label};
      if (rng_due) chk(up_range_error, rng_exp);
      if (mem_cmd_valid) chk(up_ready, 1'b0);
      rng_due = 1'b0;
      if (up_valid && up_ready) begin
        exp_mem.push_back(up_req);
        rng_due = 1'b1;
        rng_exp = up_label.label_space_nonsecure ?
          (up_label.partition_id > NS_MAX) : (up_label.partition_id > S_MAX);
      end
      if (mem_cmd_valid && mem_cmd_ready) begin
        chk(mem_cmd, exp_mem.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(32'hBFDCF1DD));
    {reset, run, slow, vmap_wr_en, req_in_valid, up_valid} = 6'h20;
    {tagging_enable, cur_secure, cur_level, virt_enable} = 8'h00;
    {vmap_wr_idx, vmap_wr_phys, req_in, up_req} = '0;
    lvl_regs = '0;
    up_label = '0;
    for (int i = 0; i < 8; i++) vmap_m[i] = 16'h0000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(proc_max, ID_MAX);
    chk({ns_max, s_max}, {NS_MAX, S_MAX});
    for (int i = 0; i < 8; i++) begin
      vmap_wr_en <= 1'b1;
      vmap_wr_idx <= 3'(i);
      vmap_wr_phys <= 16'(i * 5 + 2);
      vmap_m[i] = 16'(i * 5 + 2);
      @(posedge clk);
    end
    vmap_wr_en <= 1'b0;
    run <= 1'b1;
    repeat (400) @(posedge clk);
    slow <= 1'b1;
    repeat (800) @(posedge clk);
    slow <= 1'b0;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    chk(exp_dn.size() + exp_mem.size(), 0);
    end_of_test();
  end
endmodule
